/* File: instr_cycle_div.sv */
// Instruction-cycle enable divider
`timescale 1ns/1ps
module instr_cycle_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Enable pulse
   output logic      tcy_en
);

   logic [7:0] cnt_r;
   logic       wrap;

   // One-cycle pulse every DIV clocks
   assign wrap = (cnt_r == 8'(DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= 8'h00;
         tcy_en <= 1'b0;
      end else begin
         cnt_r  <= wrap ? 8'h00 : cnt_r + 8'h01;
         tcy_en <= wrap;
      end
   end

endmodule : instr_cycle_div

/* File: serial_tx_consts.svh */
// Offsets, bit positions, reset values and timing counts of the serial transmit block
`ifndef SERIAL_TX_CONSTS_SVH
`define SERIAL_TX_CONSTS_SVH

// Shared register word offsets (byte addresses)
`define OFS_GIC      8'h00
`define OFS_PF1      8'h04
`define OFS_PE1      8'h08
`define OFS_PP1      8'h0c
`define OFS_PF3      8'h10
`define OFS_PE3      8'h14
`define OFS_PP3      8'h18

// Per-port window: base plus port index shifted left by PORT_SHIFT
`define PORT_BASE    8'h20
`define PORT_SHIFT   5
`define OFS_RCS      8'h00
`define OFS_TXB      8'h04
`define OFS_TXS      8'h08
`define OFS_BRD      8'h0c

// Field positions
`define TXS_CLOCK_SOURCE_MASTER     7
`define TXS_NINE     6
`define TXS_TRANSMIT_ENABLE     5
`define TXS_SYNC     4
`define TXS_SHIFTER_EMPTY_STATUS     1
`define TXS_NINTH    0
`define RCS_SERIAL_PORT_ENABLE     7
`define FLAG_TX      4

// Reset values and masks
`define RST_ZERO     8'h00
`define RST_PP1      8'h7f
`define RST_PP3      8'h3f
`define RST_TXS      8'h02
`define TXS_WMASK    8'hf5
`define PF3_MASK     8'h3f

// Timing: instruction cycle and bus clock in ns
`define CLK_NS       4
`define TCY_NS       16
`define TCY_CLKS     (`TCY_NS / `CLK_NS)

`endif

/* File: serial_tx_pkg.sv */
// Types shared by the serial transmit block
package serial_tx_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef enum logic [1:0] {TX_IDLE, TX_LOW, TX_HIGH} tx_state_e;
endpackage : serial_tx_pkg

/* File: sync_master_serial_tx.sv */
// Two-port synchronous master serial transmitter with APB register access
//
// Function
// - Half duplex: transmit and receive exclude each other
// - Mode bit selects synchronous operation
// - Port enable assigns clock and data pins
// - Clock-source bit makes device drive clock
// - Shifter loads only after last bit out
// - Pending buffer word moves in automatically
// - Transfer takes one instruction cycle, raises flag
// - Flag bit 4 of flag registers one/three
// - Flag sets regardless of interrupt enable
// - Flag ignores software clears, clears on buffer write
// - Read-only shifter-empty status at bit 1
// - Shifter-empty drives no interrupt request
// - Shift register has no register address
// - Flag clears in second instruction cycle
// - Nine-bit select sends ninth data bit
// - Enable then buffer write starts shifting
// - Two identical port instances
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "serial_tx_consts.svh"
module sync_master_serial_tx #(
   parameter int TCY_DIV = `TCY_CLKS
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire serial_tx_pkg::addr_t paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Receive path status, same clock
   input  wire logic [1:0]           rx_busy,
   output logic [1:0]                receive_inhibit,
   // Transmit interrupt requests
   output logic [1:0]                tx_irq_req,
   // Shift clock pins
   output logic [1:0]                shift_clock_line_o,
   output logic [1:0]                shift_clock_line_oe,
   // Serial data pins
   output logic [1:0]                serial_data_line_o,
   output logic [1:0]                serial_data_line_oe
);
   import serial_tx_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Byte address of a register inside a port window
   function automatic addr_t port_addr(input logic p, input addr_t off);
      port_addr = `PORT_BASE + (addr_t'(p) << `PORT_SHIFT) + off;
   endfunction : port_addr

   // The shift register has no entry here on purpose
   localparam addr_t A_RCS0 = port_addr(1'b0, `OFS_RCS);
   localparam addr_t A_TXB0 = port_addr(1'b0, `OFS_TXB);
   localparam addr_t A_TXS0 = port_addr(1'b0, `OFS_TXS);
   localparam addr_t A_BRD0 = port_addr(1'b0, `OFS_BRD);
   localparam addr_t A_RCS1 = port_addr(1'b1, `OFS_RCS);
   localparam addr_t A_TXB1 = port_addr(1'b1, `OFS_TXB);
   localparam addr_t A_TXS1 = port_addr(1'b1, `OFS_TXS);
   localparam addr_t A_BRD1 = port_addr(1'b1, `OFS_BRD);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic  tcy_en;
   logic  access;
   logic  done;
   logic  wr;
   byte_t wbyte;

   byte_t gic_r;
   byte_t pf1_r;
   byte_t pe1_r;
   byte_t pp1_r;
   byte_t pf3_r;
   byte_t pe3_r;
   byte_t pp3_r;

   byte_t rcs_r     [2];
   byte_t txb_r     [2];
   byte_t txs_r     [2];
   byte_t brd_r     [2];
   logic  buf_full_r[2];
   logic  empty_d1_r[2];
   logic  flag_r    [2];
   logic  load      [2];
   logic  sh_empty  [2];
   logic  port_on   [2];
   logic  tx_on     [2];
   logic  ien       [2];

   logic  wr_gic;
   logic  wr_pf1;
   logic  wr_pe1;
   logic  wr_pp1;
   logic  wr_pf3;
   logic  wr_pe3;
   logic  wr_pp3;
   logic  wr_rcs    [2];
   logic  wr_txb    [2];
   logic  wr_txs    [2];
   logic  wr_brd    [2];

   byte_t rd_data;
   logic  rd_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction cycle enable

   // All port timing steps on this enable, never on a second clock
   instr_cycle_div #(
      .DIV    (TCY_DIV)
   ) u_tcy (
      .pclk   (pclk),
      .presetn(presetn),
      .tcy_en (tcy_en)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // APB handshake

   // One wait state so read data comes straight from a flop
   assign access = psel && penable;
   assign done   = access && pready;
   assign wr     = done && pwrite;
   assign wbyte  = pwdata[7:0];

   // Write strobes, valid only at the completing edge
   assign wr_gic = wr && (paddr == `OFS_GIC);
   assign wr_pf1 = wr && (paddr == `OFS_PF1);
   assign wr_pe1 = wr && (paddr == `OFS_PE1);
   assign wr_pp1 = wr && (paddr == `OFS_PP1);
   assign wr_pf3 = wr && (paddr == `OFS_PF3);
   assign wr_pe3 = wr && (paddr == `OFS_PE3);
   assign wr_pp3 = wr && (paddr == `OFS_PP3);
   assign wr_rcs[0] = wr && (paddr == A_RCS0);
   assign wr_txb[0] = wr && (paddr == A_TXB0);
   assign wr_txs[0] = wr && (paddr == A_TXS0);
   assign wr_brd[0] = wr && (paddr == A_BRD0);
   assign wr_rcs[1] = wr && (paddr == A_RCS1);
   assign wr_txb[1] = wr && (paddr == A_TXB1);
   assign wr_txs[1] = wr && (paddr == A_TXS1);
   assign wr_brd[1] = wr && (paddr == A_BRD1);

   // Read view; flag bits and shifter status come from live hardware state
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 8'h00;
      unique case (paddr)
         `OFS_GIC: rd_data = gic_r;
         `OFS_PF1: rd_data = {pf1_r[7:5], flag_r[0], pf1_r[3:0]};
         `OFS_PE1: rd_data = pe1_r;
         `OFS_PP1: rd_data = pp1_r;
         `OFS_PF3: rd_data = {2'b00, pf3_r[5], flag_r[1], pf3_r[3:0]};
         `OFS_PE3: rd_data = pe3_r;
         `OFS_PP3: rd_data = pp3_r;
         A_RCS0:   rd_data = rcs_r[0];
         A_TXB0:   rd_data = txb_r[0];
         A_TXS0:   rd_data = {txs_r[0][7:4], 1'b0, txs_r[0][2], sh_empty[0],
                              txs_r[0][0]};
         A_BRD0:   rd_data = brd_r[0];
         A_RCS1:   rd_data = rcs_r[1];
         A_TXB1:   rd_data = txb_r[1];
         A_TXS1:   rd_data = {txs_r[1][7:4], 1'b0, txs_r[1][2], sh_empty[1],
                              txs_r[1][0]};
         A_BRD1:   rd_data = brd_r[1];
         default:  rd_hit  = 1'b0;
      endcase
   end

   // Answer flops: data captured in the wait cycle; error stands only with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access && !pready;
         pslverr <= access && !pready && !rd_hit;
         if (access && !pready) begin
            prdata  <= (rd_hit && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared flag, enable and priority registers

   // Software writes leave flag bit 4 alone; it only follows the buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gic_r <= `RST_ZERO;
         pf1_r <= `RST_ZERO;
         pe1_r <= `RST_ZERO;
         pp1_r <= `RST_PP1;
         pf3_r <= `RST_ZERO;
         pe3_r <= `RST_ZERO;
         pp3_r <= `RST_PP3;
      end else begin
         if (wr_gic) gic_r <= wbyte;
         if (wr_pf1) pf1_r <= wbyte;
         if (wr_pe1) pe1_r <= wbyte;
         if (wr_pp1) pp1_r <= wbyte;
         if (wr_pf3) pf3_r <= wbyte & `PF3_MASK;
         if (wr_pe3) pe3_r <= wbyte & `PF3_MASK;
         if (wr_pp3) pp3_r <= wbyte & `PF3_MASK;
      end
   end

   // Interrupt enables per port, enable register one then three
   assign ien[0] = pe1_r[`FLAG_TX];
   assign ien[1] = pe3_r[`FLAG_TX];

   ////////////////////////////////////////////////////////////////////////////////
   // Port instances

   for (genvar p = 0; p < 2; p++) begin : g_port

      // Pins belong to the port only with enable, sync mode and master clock
      assign port_on[p] = rcs_r[p][`RCS_SERIAL_PORT_ENABLE] && txs_r[p][`TXS_SYNC]
                          && txs_r[p][`TXS_CLOCK_SOURCE_MASTER];
      assign tx_on[p]   = txs_r[p][`TXS_TRANSMIT_ENABLE];

      // Control, buffer and divisor registers of this port
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rcs_r[p] <= `RST_ZERO;
            txb_r[p] <= `RST_ZERO;
            txs_r[p] <= `RST_TXS & `TXS_WMASK;
            brd_r[p] <= `RST_ZERO;
         end else begin
            if (wr_rcs[p]) rcs_r[p] <= wbyte;
            if (wr_txb[p]) txb_r[p] <= wbyte;
            if (wr_txs[p]) txs_r[p] <= wbyte & `TXS_WMASK;
            if (wr_brd[p]) brd_r[p] <= wbyte;
         end
      end

      // Buffer occupancy: a write in the transfer cycle wins, so no word is lost
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            buf_full_r[p] <= 1'b0;
         end else if (wr_txb[p]) begin
            buf_full_r[p] <= 1'b1;
         end else if (load[p]) begin
            buf_full_r[p] <= 1'b0;
         end
      end

      // Flag trails the buffer by two instruction-cycle steps
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            empty_d1_r[p] <= 1'b0;
            flag_r[p]     <= 1'b0;
         end else if (tcy_en) begin
            empty_d1_r[p] <= !buf_full_r[p];
            flag_r[p]     <= empty_d1_r[p];
         end
      end

      // Request gated by the enable only; shifter status never raises one
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tx_irq_req[p] <= 1'b0;
         end else begin
            tx_irq_req[p] <= flag_r[p] && ien[p];
         end
      end

      // Shift engine of this port
      sync_tx_shifter u_shift (
         .pclk         (pclk),
         .presetn      (presetn),
         .tcy_en       (tcy_en),
         .port_on      (port_on[p]),
         .tx_on        (tx_on[p]),
         .nine_bit     (txs_r[p][`TXS_NINE]),
         .ninth_bit    (txs_r[p][`TXS_NINTH]),
         .baud_div     (brd_r[p]),
         .buf_full     (buf_full_r[p]),
         .buf_data     (txb_r[p]),
         .load         (load[p]),
         .rx_busy      (rx_busy[p]),
         .shifter_empty(sh_empty[p]),
         .tx_busy      (receive_inhibit[p]),
         .ck_o         (shift_clock_line_o[p]),
         .ck_oe        (shift_clock_line_oe[p]),
         .dt_o         (serial_data_line_o[p]),
         .dt_oe        (serial_data_line_oe[p])
      );
   end

endmodule : sync_master_serial_tx

/* File: sync_master_serial_tx_tb.sv */
// Self-checking bench of the two-port synchronous master transmitter
`timescale 1ns/1ps
`include "serial_tx_consts.svh"
module sync_master_serial_tx_tb;
   import serial_tx_pkg::*;
   localparam addr_t P0 = `PORT_BASE;
   localparam addr_t P1 = `PORT_BASE + 8'h20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   addr_t       paddr;
   byte_t       rd;
   logic [31:0] pwdata, prdata;
   logic [1:0]  rx_busy, rinh, irq, ck_o, ck_oe, dt_o, dt_oe;
   wire  [1:0]  ck_w, dt_w;
   logic [3:0]  nbits [2];
   logic [8:0]  lw [2];
   logic [7:0]  wc [2];
   int          fail_count, samples_checked;
   addr_t ra [9] = '{`OFS_GIC, `OFS_PF1, `OFS_PE1, `OFS_PP1, `OFS_PF3, `OFS_PE3, `OFS_PP3,
                     P0 + `OFS_TXS, P1 + `OFS_TXS};
   byte_t re [9] = '{8'h00, 8'h10, 8'h00, 8'h7f, 8'h10, 8'h00, 8'h3f, 8'h02, 8'h02};
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////////
   sync_master_serial_tx #(.TCY_DIV(2)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_busy(rx_busy), .receive_inhibit(rinh), .tx_irq_req(irq),
      .shift_clock_line_o(ck_o), .shift_clock_line_oe(ck_oe),
      .serial_data_line_o(dt_o), .serial_data_line_oe(dt_oe));
   // Released lines float so a slave never reads a stale bit
   for (genvar i = 0; i < 2; i++) begin : g_pin
      assign ck_w[i] = ck_oe[i] ? ck_o[i] : 1'bz;
      assign dt_w[i] = dt_oe[i] ? dt_o[i] : 1'bz;
      sync_slave_model u_slv (.ck(ck_w[i]), .dt(dt_w[i]), .nbits(nbits[i]),
                              .last_word(lw[i]), .word_count(wc[i]));
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer; holds everything until pready is seen
   task automatic apb(input logic wr, input addr_t a, input byte_t d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) fail_count++;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input addr_t a, input byte_t e);
      apb(1'b0, a, 8'h00);
      check({1'b0, rd}, {1'b0, e});
   endtask : rchk
   task automatic wait_words(input int p, input int n);
      int k;
      k = 0;
      while (wc[p] < n && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 3000) fail_count++;
   endtask : wait_words
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      results();
   end
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx_busy = 2'b00;
      nbits[0] = 4'd8;
      nbits[1] = 4'd9;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
      foreach (ra[i]) rchk(ra[i], re[i]);
      apb(1'b0, 8'h1c, 8'h00);
      check({err, rd}, 9'h100);
      $display("test reset done");
      apb(1'b1, `OFS_PF1, 8'h00);
      apb(1'b1, `OFS_PF3, 8'h00);
      apb(1'b1, `OFS_PE1, 8'h10);
      apb(1'b1, `OFS_PE3, 8'h10);
      rchk(`OFS_PF1, 8'h10);
      rchk(`OFS_PF3, 8'h10);
      check({7'h0, irq}, 9'h003);
      // Busy receiver holds the word in the buffer
      rx_busy <= 2'b01;
      apb(1'b1, P0 + `OFS_BRD, 8'h01);
      apb(1'b1, P0 + `OFS_RCS, 8'h80);
      apb(1'b1, P0 + `OFS_TXS, 8'hb0);
      // Pin enables are registered one edge after the control write lands
      repeat (2) @(negedge pclk);
      check({8'h0, dt_oe[0]}, 9'h000);
      check({8'h0, ck_oe[0]}, 9'h001);
      apb(1'b1, P0 + `OFS_TXB, 8'ha5);
      @(negedge pclk);
      check({8'h0, irq[0]}, 9'h001);
      repeat (10) @(negedge pclk);
      check({8'h0, irq[0]}, 9'h000);
      rchk(P0 + `OFS_TXS, 8'hb2);
      rx_busy <= 2'b00;
      repeat (6) @(posedge pclk);
      check({8'h0, rinh[0]}, 9'h001);
      apb(1'b1, P0 + `OFS_TXB, 8'h3c);
      rchk(P0 + `OFS_TXS, 8'hb0);
      wait_words(0, 1);
      check(lw[0], 9'h0a5);
      wait_words(0, 2);
      check(lw[0], 9'h03c);
      repeat (20) @(posedge pclk);
      rchk(P0 + `OFS_TXS, 8'hb2);
      rchk(`OFS_PF1, 8'h10);
      $display("test port zero done");
      apb(1'b1, P1 + `OFS_BRD, 8'h01);
      apb(1'b1, P1 + `OFS_RCS, 8'h80);
      apb(1'b1, P1 + `OFS_TXS, 8'hf1);
      apb(1'b1, P1 + `OFS_TXB, 8'h5a);
      wait_words(1, 1);
      check(lw[1], 9'h15a);
      repeat (20) @(posedge pclk);
      rchk(`OFS_PF3, 8'h10);
      rchk(P1 + `OFS_TXS, 8'hf3);
      check({7'h0, irq}, 9'h003);
      $display("test port one done");
      results();
   end
endmodule : sync_master_serial_tx_tb
bind sync_master_serial_tx sync_tx_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_busy(rx_busy), .receive_inhibit(receive_inhibit), .tx_irq_req(tx_irq_req),
   .shift_clock_line_o(shift_clock_line_o), .shift_clock_line_oe(shift_clock_line_oe),
   .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe));

/* File: sync_slave_model.sv */
// External synchronous slave that receives clocked serial words
`timescale 1ns/1ps
module sync_slave_model (
   // Link pins
   input  wire logic       ck,
   input  wire logic       dt,
   // Frame length in bits
   input  wire logic [3:0] nbits,
   // Received words
   output logic [8:0]      last_word,
   output logic [7:0]      word_count
);
   logic [8:0] sh;
   logic [3:0] n;
   initial begin
      sh = 9'h000;
      n = 4'h0;
      last_word = 9'h000;
      word_count = 8'h00;
   end
   // Samples on the rising clock, first bit lands lowest
   always @(posedge ck) begin
      sh = {dt, sh[8:1]};
      n = n + 4'h1;
      if (n == nbits) begin
         last_word <= sh >> (4'd9 - nbits);
         word_count <= word_count + 8'h01;
         n = 4'h0;
      end
   end
endmodule : sync_slave_model

/* File: sync_tx_monitor.sv */
// Checker of the transmitter's port behaviour
`timescale 1ns/1ps
module sync_tx_monitor (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // APB
   input wire serial_tx_pkg::addr_t paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Link side
   input wire logic [1:0]           rx_busy,
   input wire logic [1:0]           receive_inhibit,
   input wire logic [1:0]           tx_irq_req,
   input wire logic [1:0]           shift_clock_line_o,
   input wire logic [1:0]           shift_clock_line_oe,
   input wire logic [1:0]           serial_data_line_o,
   input wire logic [1:0]           serial_data_line_oe
);
   import serial_tx_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // APB access has exactly one wait state
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   property p_one_wait;
      s_wait |=> s_done;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("access wait wrong");
   property p_ready_pulse;
      s_done |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   ////////////////////////////////////////////////////////////////////////////////
   // Link pins; a busy receiver owns the data line
   property p_rx_release;
      rx_busy[0] [*2] |-> !serial_data_line_oe[0];
   endproperty
   a_rx_release: assert property (p_rx_release) else $error("data driven in rx");
   property p_clk_inhibit;
      $rose(shift_clock_line_o[0]) |-> receive_inhibit[0];
   endproperty
   a_clk_inhibit: assert property (p_clk_inhibit) else $error("rx not inhibited");
   property p_clk_driven;
      shift_clock_line_o[0] |-> shift_clock_line_oe[0];
   endproperty
   a_clk_driven: assert property (p_clk_driven) else $error("clock not driven");
   property p_half_min;
      $changed(shift_clock_line_o[0]) |=> $stable(shift_clock_line_o[0]);
   endproperty
   a_half_min: assert property (p_half_min) else $error("clock phase short");
   property p_dt_low;
      serial_data_line_oe[0] && $changed(serial_data_line_o[0]) |-> !shift_clock_line_o[0];
   endproperty
   a_dt_low: assert property (p_dt_low) else $error("data moved, clock high");
   property p_end_low;
      $fell(receive_inhibit[0]) |-> !shift_clock_line_o[0];
   endproperty
   a_end_low: assert property (p_end_low) else $error("frame ends clock high");
   property p_port1_clk;
      $rose(shift_clock_line_o[1]) |-> receive_inhibit[1] && shift_clock_line_oe[1];
   endproperty
   a_port1_clk: assert property (p_port1_clk) else $error("port one clock");
endmodule : sync_tx_monitor

/* File: sync_tx_shifter.sv */
// Shift engine of one synchronous master transmit port
`timescale 1ns/1ps
module sync_tx_shifter (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 tcy_en,
   // Configuration
   input  wire logic                 port_on,
   input  wire logic                 tx_on,
   input  wire logic                 nine_bit,
   input  wire logic                 ninth_bit,
   input  wire serial_tx_pkg::byte_t baud_div,
   // Buffer handoff
   input  wire logic                 buf_full,
   input  wire serial_tx_pkg::byte_t buf_data,
   output logic                      load,
   // Status
   input  wire logic                 rx_busy,
   output logic                      shifter_empty,
   output logic                      tx_busy,
   // Pins
   output logic                      ck_o,
   output logic                      ck_oe,
   output logic                      dt_o,
   output logic                      dt_oe
);
   import serial_tx_pkg::*;

   tx_state_e  state_r;
   logic [8:0] shift_r;
   logic [3:0] left_r;
   byte_t      baud_r;
   logic       tick;
   logic       run;

   // Baud tick: every baud_div+1 instruction cycles, one half shift clock
   assign tick = tcy_en && (baud_r == 8'h00) && (state_r != TX_IDLE);
   assign run  = port_on && tx_on;
   // Load only into an empty shifter, one instruction cycle, not while receiving
   assign load = tcy_en && run && buf_full && (state_r == TX_IDLE) && !rx_busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r       <= TX_IDLE;
         shift_r       <= 9'h000;
         left_r        <= 4'h0;
         baud_r        <= 8'h00;
         shifter_empty <= 1'b1;
         tx_busy       <= 1'b0;
         ck_o          <= 1'b0;
         ck_oe         <= 1'b0;
         dt_o          <= 1'b0;
         dt_oe         <= 1'b0;
      end else begin
         ck_oe   <= port_on;
         dt_oe   <= port_on && !rx_busy;
         tx_busy <= (state_r != TX_IDLE) || load;
         if (tcy_en && state_r != TX_IDLE) begin
            baud_r <= (baud_r == 8'h00) ? baud_div : baud_r - 8'h01;
         end
         if (!run) begin
            // Dropping the enable abandons the word in flight
            state_r       <= TX_IDLE;
            shifter_empty <= 1'b1;
            ck_o          <= 1'b0;
         end else if (load) begin
            shift_r       <= {ninth_bit, buf_data};
            left_r        <= nine_bit ? 4'd9 : 4'd8;
            dt_o          <= buf_data[0];
            baud_r        <= baud_div;
            state_r       <= TX_LOW;
            shifter_empty <= 1'b0;
         end else if (tick) begin
            unique case (state_r)
               TX_LOW: begin
                  ck_o    <= 1'b1;
                  state_r <= TX_HIGH;
               end
               TX_HIGH: begin
                  ck_o <= 1'b0;
                  if (left_r == 4'd1) begin
                     state_r       <= TX_IDLE;
                     shifter_empty <= 1'b1;
                  end else begin
                     shift_r <= {1'b0, shift_r[8:1]};
                     dt_o    <= shift_r[1];
                     left_r  <= left_r - 4'd1;
                     state_r <= TX_LOW;
                  end
               end
               TX_IDLE: state_r <= TX_IDLE;
            endcase
         end
      end
   end

endmodule : sync_tx_shifter
